// >>> kih_top.sv
// keypad interrupt handler: edge select, mask, status and irq line
// Function
// - status bits: missing, timeout, long key, press
// - missing event works only in test mode
// - mask bit one blocks event request
// - all mask bits one after reset
// - mask written on the interface clock
// - two-bit edge select: fall, rise, both, off
// - edge pairs at 7:6, 5:4, 3:2, 1:0
// - reset: falling enabled, rising disabled everywhere
// - pending disable bit drops events during latency
// - clear-on-read: status read clears status
// - otherwise write one clears status bit
// - otherwise read of clear address clears all
// - control bits reset zero, reserved read zero
`timescale 1ns/1ps
`default_nettype none

module kih_top
(
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire logic                  test_mode,
    input  wire logic [3:0]            event_in,
    input  wire kih_pkg::kih_reg_req_t reg_req,
    output kih_pkg::kih_reg_rsp_t      reg_rsp,
    output logic                       keypad_irq_line_n
);

    ////////////////////////////////////////////////////////////////////////////////
    // register state

    logic [3:0] mask_q;
    logic [7:0] edge_q;
    logic       cor_q;
    logic       pend_q;

    kih_pkg::kih_reg_rsp_t rsp_q;
    logic                  irq_n_q;

    logic [3:0] status;
    logic [3:0] pending;
    logic [3:0] edge_hit;
    logic [3:0] clear;
    logic [3:0] event_en;

    ////////////////////////////////////////////////////////////////////////////////
    // address decode

    logic hit_status;
    logic hit_mask;
    logic hit_edge;
    logic hit_ctrl;
    logic hit_clear_all;

    // one-hot selects of the mapped registers
    assign hit_status    = (reg_req.addr == kih_pkg::STATUS_OFFSET);
    assign hit_mask      = (reg_req.addr == kih_pkg::MASK_OFFSET);
    assign hit_edge      = (reg_req.addr == kih_pkg::EDGE_OFFSET);
    assign hit_ctrl      = (reg_req.addr == kih_pkg::CTRL_OFFSET);
    assign hit_clear_all = (reg_req.addr == kih_pkg::CLEAR_ALL_OFFSET);

    ////////////////////////////////////////////////////////////////////////////////
    // writable registers

    // mask register, all events masked out of reset
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            mask_q <= kih_pkg::MASK_RESET;
        else if (reg_req.wr && hit_mask)
            mask_q <= reg_req.wdata[3:0];
    end

    // edge selection pairs, falling edge on for every event after reset
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            edge_q <= kih_pkg::EDGE_RESET;
        else if (reg_req.wr && hit_edge)
            edge_q <= reg_req.wdata;
    end

    // handler control: clear-on-read and pending capture disable
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            cor_q  <= kih_pkg::COR_RESET;
            pend_q <= kih_pkg::PEND_RESET;
        end
        else if (reg_req.wr && hit_ctrl)
        begin
            cor_q  <= reg_req.wdata[kih_pkg::CTRL_COR_BIT];
            pend_q <= reg_req.wdata[kih_pkg::CTRL_PEND_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status clear sources

    logic       clear_read;
    logic       clear_all;
    logic [3:0] clear_write;

    // a read of status in clear-on-read mode wipes the whole register
    assign clear_read = cor_q & reg_req.rd & hit_status;

    // without clear-on-read, a read of the dedicated address wipes everything
    assign clear_all = ~cor_q & reg_req.rd & hit_clear_all;

    // without clear-on-read, a one written to a status bit clears that bit
    assign clear_write = (~cor_q & reg_req.wr & hit_status) ? reg_req.wdata[3:0] : 4'h0;

    assign clear = clear_write | {4{clear_read | clear_all}};

    ////////////////////////////////////////////////////////////////////////////////
    // per-event detection and status

    // the missing event is live only in test mode
    assign event_en = {test_mode, 3'b111};

    genvar gi;
    generate
        for (gi = 0; gi < kih_pkg::NUM_EVENTS; gi++)
        begin : g_event
            kih_edge_detect u_edge
            (
                .mclk     (mclk),
                .rstn     (rstn),
                .level    (event_in[gi]),
                .rise_en  (edge_q[2*gi + kih_pkg::EDGE_RISE_BIT]),
                .fall_en  (edge_q[2*gi + kih_pkg::EDGE_FALL_BIT]),
                .enable   (event_en[gi]),
                .edge_hit (edge_hit[gi])
            );

            kih_status_cell u_status
            (
                .mclk         (mclk),
                .rstn         (rstn),
                .edge_hit     (edge_hit[gi]),
                .clear        (clear[gi]),
                .pend_disable (pend_q),
                .status       (status[gi]),
                .pending      (pending[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt line

    // low while any unmasked status bit is set
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            irq_n_q <= kih_pkg::IRQ_N_RESET;
        else
            irq_n_q <= ~|(status & ~mask_q);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path

    logic [7:0] rdata_d;

    // read mux; reserved bits and unmapped addresses read as zero
    always_comb
    begin
        rdata_d = 8'h00;
        case (1'b1)
            hit_status: rdata_d = {4'h0, status};
            hit_mask:   rdata_d = {4'h0, mask_q};
            hit_edge:   rdata_d = edge_q;
            hit_ctrl:   rdata_d = {5'h00, cor_q, pend_q, 1'b0};
            default:    rdata_d = 8'h00;
        endcase
    end

    // answer one cycle after the read request, shows status before any clear
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            rsp_q.valid <= 1'b0;
            rsp_q.data  <= kih_pkg::RDATA_RESET;
        end
        else
        begin
            rsp_q.valid <= reg_req.rd;
            if (reg_req.rd)
                rsp_q.data <= rdata_d;
        end
    end

    assign reg_rsp           = rsp_q;
    assign keypad_irq_line_n = irq_n_q;

endmodule

`default_nettype wire

// >>> kih_pkg.sv
// constants and carrier types for the keypad interrupt handler
`default_nettype none

package kih_pkg;

    // event count and event bit positions
    localparam int NUM_EVENTS = 4;
    localparam int EV_KEY_PRESS = 0;
    localparam int EV_LONG_KEY  = 1;
    localparam int EV_TIMEOUT   = 2;
    localparam int EV_MISSING   = 3;

    // register offsets on the register access port
    localparam logic [7:0] STATUS_OFFSET    = 8'he3;
    localparam logic [7:0] MASK_OFFSET      = 8'he4;
    localparam logic [7:0] EDGE_OFFSET      = 8'he8;
    localparam logic [7:0] CTRL_OFFSET      = 8'he9;
    localparam logic [7:0] CLEAR_ALL_OFFSET = 8'hea;

    // field positions
    localparam int EDGE_FALL_BIT = 0;
    localparam int EDGE_RISE_BIT = 1;
    localparam int CTRL_PEND_BIT = 1;
    localparam int CTRL_COR_BIT  = 2;

    // reset values
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET   = 4'hf;
    localparam logic [7:0] EDGE_RESET   = 8'h55;
    localparam logic       COR_RESET    = 1'b0;
    localparam logic       PEND_RESET   = 1'b0;
    localparam logic [7:0] RDATA_RESET  = 8'h00;
    localparam logic       IRQ_N_RESET  = 1'b1;

    // one register access request, taken in one cycle
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } kih_reg_req_t;

    // read answer, valid for one cycle
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } kih_reg_rsp_t;

endpackage

`default_nettype wire

// >>> kih_edge_detect.sv
// edge detector for one keypad event with selectable polarity
`timescale 1ns/1ps
`default_nettype none

module kih_edge_detect
(
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic level,
    input  wire logic rise_en,
    input  wire logic fall_en,
    input  wire logic enable,
    output logic      edge_hit
);

    logic prev_q;
    logic valid_q;

    // previous level of the event input
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            prev_q <= 1'b0;
        else
            prev_q <= level;
    end

    // no edge is reported until one real sample of the level is held
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            valid_q <= 1'b0;
        else
            valid_q <= 1'b1;
    end

    // 01 fall, 10 rise, 11 both, 00 off
    assign edge_hit = enable & valid_q &
                      ((rise_en & level & ~prev_q) | (fall_en & ~level & prev_q));

endmodule

`default_nettype wire

// >>> kih_status_cell.sv
// sticky status bit for one event with optional pending capture
`timescale 1ns/1ps
`default_nettype none

module kih_status_cell
(
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic edge_hit,
    input  wire logic clear,
    input  wire logic pend_disable,
    output logic      status,
    output logic      pending
);

    logic status_q;
    logic pending_q;

    // set wins over clear; a held pending event reloads the bit once it is clear
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            status_q <= 1'b0;
        else
            status_q <= edge_hit | (status_q & ~clear) | (pending_q & ~status_q);
    end

    // events seen while the bit is already set wait here unless capture is off
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            pending_q <= 1'b0;
        else if (pend_disable)
            pending_q <= 1'b0;
        else if (edge_hit & status_q & ~clear)
            pending_q <= 1'b1;
        else if (!status_q)
            pending_q <= 1'b0;
    end

    assign status  = status_q;
    assign pending = pending_q;

endmodule

`default_nettype wire

// >>> kih_properties.sv
// port assertions for the keypad interrupt handler
`timescale 1ns/1ps
`default_nettype none

module kih_props
(
    input wire logic                  mclk,
    input wire logic                  rstn,
    input wire logic                  test_mode,
    input wire kih_pkg::kih_reg_req_t reg_req,
    input wire kih_pkg::kih_reg_rsp_t reg_rsp,
    input wire logic                  keypad_irq_line_n
);
    logic rd_s;
    logic rd_c;
    logic unm_q;
    logic tm_q;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    // status and control read decodes
    assign rd_s = reg_req.rd && reg_req.addr == kih_pkg::STATUS_OFFSET;
    assign rd_c = reg_req.rd && reg_req.addr == kih_pkg::CTRL_OFFSET;

    // history since reset: mask ever written, test mode ever seen
    always_ff @(posedge mclk)
    begin
        unm_q <= rstn && (unm_q || reg_req.wr && reg_req.addr == kih_pkg::MASK_OFFSET);
        tm_q  <= rstn && (tm_q || test_mode);
    end

    a_read_answer: assert property (reg_req.rd |=> reg_rsp.valid)
        else $error("read not answered");
    a_valid_cause: assert property (reg_rsp.valid |-> $past(reg_req.rd))
        else $error("answer without read");
    a_data_holds: assert property (!reg_req.rd |=> $stable(reg_rsp.data))
        else $error("read data moved");
    a_upper_zero:
        assert property (reg_req.rd && reg_req.addr != kih_pkg::EDGE_OFFSET |=>
                         reg_rsp.data[7:4] == 4'h0) else $error("upper bits set");
    a_ctrl_reserved: assert property (rd_c |=> !reg_rsp.data[3] && !reg_rsp.data[0])
        else $error("control reserved set");
    a_missing_gated: assert property (rd_s && !tm_q && !test_mode |=> !reg_rsp.data[3])
        else $error("missing event outside test mode");
    a_masked_quiet: assert property (!unm_q |-> keypad_irq_line_n)
        else $error("irq while all masked");
    a_reset_idle:
        assert property (disable iff (1'b0) !rstn |=> keypad_irq_line_n && reg_rsp == '0)
        else $error("outputs not idle in reset");

    c_irq: cover property (!keypad_irq_line_n);
    c_hit: cover property (rd_s ##1 reg_rsp.data[3:0] != 4'h0);
    c_cor: cover property (rd_c ##1 reg_rsp.data[2]);
endmodule

bind kih_top kih_props i_props (.mclk, .rstn, .test_mode, .reg_req, .reg_rsp,
    .keypad_irq_line_n);

`default_nettype wire

// >>> kih_host.sv
// host model driving the register byte port
`timescale 1ns/1ps
`default_nettype none

module kih_host
(
    input  wire logic                  mclk,
    output var kih_pkg::kih_reg_req_t  reg_req,
    input  wire kih_pkg::kih_reg_rsp_t reg_rsp
);
    initial reg_req = '0;

    // one strobe over one edge; released fields show inverted values
    task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] v,
                        output logic [7:0] d);
        @(negedge mclk);
        reg_req = {r, !r, a, v};
        @(negedge mclk);
        reg_req = {2'b00, ~a, ~v};
        d = reg_rsp.valid ? reg_rsp.data : 8'hxx;
    endtask
endmodule

`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the keypad interrupt handler
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam logic [7:0] STA = kih_pkg::STATUS_OFFSET;
    localparam logic [7:0] MSK = kih_pkg::MASK_OFFSET;
    localparam logic [7:0] EDG = kih_pkg::EDGE_OFFSET;
    localparam logic [7:0] CTL = kih_pkg::CTRL_OFFSET;
    logic                  mclk = 1'b0;
    logic                  rstn = 1'b0;
    logic                  test_mode = 1'b0;
    logic [3:0]            ev = 4'hf;
    kih_pkg::kih_reg_req_t req;
    kih_pkg::kih_reg_rsp_t rsp;
    logic                  irq_n;
    logic [7:0]            d;
    int                    n_fail = 0;
    int                    n_compared = 0;

    kih_top i_dut (.mclk(mclk), .rstn(rstn), .test_mode(test_mode), .event_in(ev),
        .reg_req(req), .reg_rsp(rsp), .keypad_irq_line_n(irq_n));
    kih_host i_host (.mclk(mclk), .reg_req(req), .reg_rsp(rsp));

    // clock and cycle ceiling
    initial forever #10 mclk = ~mclk;
    initial
    begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        summarize();
    end

    task automatic summarize;
        if (n_fail == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        i_host.xfer(1'b0, a, v, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        i_host.xfer(1'b1, a, 8'h00, d);
        chk("rdata", d, exp);
    endtask

    task automatic irq(input logic exp);
        chk("irq_n", {7'h0, irq_n}, {7'h0, exp});
    endtask

    // event level change, then time for status and irq to settle
    task automatic evt(input int i, input logic v);
        @(negedge mclk);
        ev[i] = v;
        repeat (3) @(negedge mclk);
    endtask

    task automatic t_reset;
        rdc(MSK, 8'h0f);
        rdc(EDG, 8'h55);
        rdc(STA, 8'h00);
        rdc(CTL, 8'h00);
        rdc(8'h00, 8'h00);
        wr(CTL, 8'hff);
        rdc(CTL, 8'h06);
        wr(CTL, 8'h00);
    endtask

    task automatic t_missing;
        wr(MSK, 8'h00);
        wr(EDG, 8'hc0);
        evt(3, 1'b0);
        evt(3, 1'b1);
        rdc(STA, 8'h00);
        irq(1'b1);
    endtask

    task automatic t_edges;
        test_mode = 1'b1;
        for (int i = 0; i < 4; i++)
            for (int m = 0; m < 4; m++)
            begin
                wr(EDG, 8'(m << (2 * i)));
                evt(i, 1'b0);
                rdc(STA, 8'(m % 2 << i));
                irq(m % 2 == 0);
                wr(STA, 8'h0f);
                evt(i, 1'b1);
                rdc(STA, 8'(m / 2 << i));
                wr(STA, 8'h0f);
            end
    endtask

    task automatic t_mask;
        wr(MSK, 8'h0f);
        wr(EDG, 8'h55);
        evt(1, 1'b0);
        rdc(STA, 8'h02);
        irq(1'b1);
        wr(MSK, 8'h0d);
        repeat (2) @(negedge mclk);
        irq(1'b0);
        rdc(MSK, 8'h0d);
        evt(1, 1'b1);
        wr(STA, 8'h02);
    endtask

    // clear-on-read: status writes ignored, clear-all address idle, a status read wipes
    task automatic t_cor;
        wr(CTL, 8'h04);
        evt(1, 1'b0);
        irq(1'b0);
        wr(STA, 8'h02);
        rdc(STA, 8'h02);
        rdc(STA, 8'h00);
        irq(1'b1);
        evt(1, 1'b1);
        evt(1, 1'b0);
        rdc(kih_pkg::CLEAR_ALL_OFFSET, 8'h00);
        rdc(STA, 8'h02);
        evt(1, 1'b1);
        wr(CTL, 8'h00);
    endtask

    task automatic t_clear;
        evt(0, 1'b0);
        evt(2, 1'b0);
        rdc(STA, 8'h05);
        rdc(kih_pkg::CLEAR_ALL_OFFSET, 8'h00);
        rdc(STA, 8'h00);
        evt(0, 1'b1);
        evt(2, 1'b1);
    endtask

    // second edge while set, then clear: held or dropped per control
    task automatic t_pend(input logic [7:0] c, input logic [7:0] exp);
        wr(CTL, c);
        wr(EDG, 8'h03);
        evt(0, 1'b0);
        evt(0, 1'b1);
        wr(STA, 8'h01);
        repeat (2) @(negedge mclk);
        rdc(STA, exp);
        wr(STA, 8'h01);
    endtask

    // main sequence
    initial
    begin
        repeat (20) @(negedge mclk);
        rstn = 1'b1;
        t_reset();
        t_missing();
        t_edges();
        t_mask();
        t_cor();
        t_clear();
        t_pend(8'h00, 8'h01);
        t_pend(8'h02, 8'h00);
        summarize();
    end
endmodule

`default_nettype wire
